// *** pkg/pwm_params.svh ***
// Register offsets, field positions, reset values and timing constants of the PWM block
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH

`define OFS_CH0_DUTY_LOW   12'h000
`define OFS_CH0_DUTY_HIGH  12'h004
`define OFS_CH1_DUTY_LOW   12'h008
`define OFS_CH1_DUTY_HIGH  12'h00C
`define OFS_CH2_DUTY_LOW   12'h010
`define OFS_CH2_DUTY_HIGH  12'h014
`define OFS_BASE_PERIOD_0  12'h018
`define OFS_BASE_PERIOD_1  12'h01C
`define OFS_BASE_PERIOD_2  12'h020
`define OFS_CLK_SELECT     12'h024
`define OFS_PORTA_DIR      12'h028
`define OFS_PORTB_DIR      12'h02C
`define OFS_PORTA_DATA     12'h030
`define OFS_PORTB_DATA     12'h034
`define OFS_PIN_STATUS     12'h038

`define LOW_ENABLE_BIT     0
`define LOW_FRAC_LSB       1
`define WAVE_OUT_0_BIT     4
`define WAVE_OUT_1_BIT     5
`define WAVE_OUT_2_BIT     0

`define RESET_BYTE         8'h00
`define RESET_DIR          8'hFF
`define QUARTER_DIV        2'h3
`define SUBCYCLE_LAST      4'hF
`define SLOT_LAST          8'hFF

`endif

// *** pkg/pwm_pkg.sv ***
// Types shared by the PWM block
package pwm_pkg;
  typedef struct packed {
    logic [7:0] coarse;
    logic [3:0] frac;
  } duty_t;

  typedef struct packed {
    logic [7:0] period;
    logic       quarter;
    duty_t      duty;
  } chan_cfg_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
endpackage

// *** src/pwm_channel.sv ***
// One 8+4 PWM channel: prescaler, 4096-step cycle and waveform
`timescale 1ns/10ps
`include "pwm_params.svh"
module pwm_channel (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              quarter_tick,
  input  wire pwm_pkg::chan_cfg_t cfg,
  output logic                   wave
);
  logic [7:0]         presc_r;
  logic [7:0]         slot_r;
  logic [3:0]         sub_r;
  pwm_pkg::duty_t     act_r;
  logic               src_tick;
  logic               step;
  logic [8:0]         high_len;

  // Prescaler input is system clock or system clock / 4
  assign src_tick = cfg.quarter ? quarter_tick : 1'b1;
  assign step     = src_tick && (presc_r == cfg.period);

  // Prescaler: one PWM clock lasts period+1 source clocks
  always_ff @(posedge clk) begin
    if (reset) begin
      presc_r <= `RESET_BYTE;
    end else if (src_tick) begin
      presc_r <= (presc_r == cfg.period) ? `RESET_BYTE : presc_r + 8'h01;
    end
  end

  // Slot and sub-cycle counters: 16 sub-cycles of 256 PWM clocks
  always_ff @(posedge clk) begin
    if (reset) begin
      slot_r <= `RESET_BYTE;
      sub_r  <= 4'h0;
    end else if (step) begin
      slot_r <= slot_r + 8'h01;
      if (slot_r == `SLOT_LAST) begin
        sub_r <= sub_r + 4'h1;
      end
    end
  end

  // Duty captured only at full-cycle start, so no cycle mixes values
  always_ff @(posedge clk) begin
    if (reset) begin
      act_r <= '0;
    end else if (step && slot_r == `SLOT_LAST && sub_r == `SUBCYCLE_LAST) begin
      act_r <= cfg.duty;
    end
  end

  // Coarse plus one extra clock in sub-cycles below the fraction
  assign high_len = {1'b0, act_r.coarse} + {8'h00, (sub_r < act_r.frac)};

  always_ff @(posedge clk) begin
    if (reset) begin
      wave <= 1'b0;
    end else begin
      wave <= ({1'b0, slot_r} < high_len);
    end
  end
endmodule

// *** src/pwm_top.sv ***
// Three-channel 8+4 PWM with port pin muxing and AXI4-Lite registers
`timescale 1ns/10ps
`include "pwm_params.svh"
module pwm_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        porta_bit4_in,
  input  wire logic        porta_bit5_in,
  input  wire logic        portb_bit0_in,
  output logic             porta_bit4_out,
  output logic             porta_bit4_oe,
  output logic             porta_bit5_out,
  output logic             porta_bit5_oe,
  output logic             portb_bit0_out,
  output logic             portb_bit0_oe
);
  logic [7:0]          duty_low_r [3];
  logic [7:0]          duty_high_r [3];
  logic [7:0]          base_period_r [3];
  logic [2:0]          clk_sel_r;
  logic [7:0]          porta_direction_r;
  logic [7:0]          portb_direction_r;
  logic [7:0]          porta_output_data_r;
  logic [7:0]          portb_output_data_r;
  logic [1:0]          quarter_r;
  logic                quarter_tick;
  logic [2:0]          wave;
  logic [2:0]          pin_dir_in;
  logic [2:0]          pin_data;
  logic [2:0]          pin_out_nxt;
  logic [2:0]          pin_oe_nxt;
  logic [2:0]          in_meta_r;
  logic [2:0]          in_sync_r;
  logic [11:0]         aw_r;
  logic [31:0]         w_r;
  logic [3:0]          ws_r;
  logic                aw_have_r;
  logic                w_have_r;
  logic                do_write;
  logic [31:0]         rd_val;
  pwm_pkg::wr_state_t  wr_state_r;
  pwm_pkg::rd_state_t  rd_state_r;

  // Register decode shared by read and write paths
  function automatic logic known_addr(input logic [11:0] a);
    case (a)
      `OFS_CH0_DUTY_LOW, `OFS_CH0_DUTY_HIGH, `OFS_CH1_DUTY_LOW, `OFS_CH1_DUTY_HIGH,
      `OFS_CH2_DUTY_LOW, `OFS_CH2_DUTY_HIGH, `OFS_BASE_PERIOD_0, `OFS_BASE_PERIOD_1,
      `OFS_BASE_PERIOD_2, `OFS_CLK_SELECT, `OFS_PORTA_DIR, `OFS_PORTB_DIR,
      `OFS_PORTA_DATA, `OFS_PORTB_DATA, `OFS_PIN_STATUS: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  endfunction

  // Divide-by-four tick for the slow prescaler source
  always_ff @(posedge clk) begin
    if (reset) begin
      quarter_r <= 2'h0;
    end else begin
      quarter_r <= quarter_r + 2'h1;
    end
  end
  // One divider feeds all channels, so their slow sources stay in step
  assign quarter_tick = (quarter_r == `QUARTER_DIV);

  // Per-channel waveform generators
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_ch
      pwm_pkg::chan_cfg_t cfg;
      assign cfg.period       = base_period_r[g];
      assign cfg.quarter      = clk_sel_r[g];
      assign cfg.duty.coarse  = duty_high_r[g];
      assign cfg.duty.frac    = duty_low_r[g][4:`LOW_FRAC_LSB];
      pwm_channel u_ch (
        .clk          (clk),
        .reset        (reset),
        .quarter_tick (quarter_tick),
        .cfg          (cfg),
        .wave         (wave[g])
      );
    end
  endgenerate

  // Channel-to-pin assignment
  assign pin_dir_in = {portb_direction_r[`WAVE_OUT_2_BIT], porta_direction_r[`WAVE_OUT_1_BIT],
                       porta_direction_r[`WAVE_OUT_0_BIT]};
  // Data bits double as the on/off gate of each routed waveform
  assign pin_data   = {portb_output_data_r[`WAVE_OUT_2_BIT],
                       porta_output_data_r[`WAVE_OUT_1_BIT],
                       porta_output_data_r[`WAVE_OUT_0_BIT]};

  // Pin mux: enable picks wave gated by data, else plain port data
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_oe_nxt[i] = ~pin_dir_in[i];
      if (duty_low_r[i][`LOW_ENABLE_BIT]) begin
        pin_out_nxt[i] = pin_data[i] & wave[i];
      end else begin
        pin_out_nxt[i] = pin_data[i];
      end
    end
  end

  // Registered pin drive, one cycle behind the waveform
  always_ff @(posedge clk) begin
    if (reset) begin
      {portb_bit0_out, porta_bit5_out, porta_bit4_out} <= 3'h0;
      {portb_bit0_oe, porta_bit5_oe, porta_bit4_oe}    <= 3'h0;
    end else begin
      {portb_bit0_out, porta_bit5_out, porta_bit4_out} <= pin_out_nxt;
      {portb_bit0_oe, porta_bit5_oe, porta_bit4_oe}    <= pin_oe_nxt;
    end
  end

  // Two-flop synchroniser on the pin inputs; pins read back as inputs
  always_ff @(posedge clk) begin
    if (reset) begin
      in_meta_r <= 3'h0;
      in_sync_r <= 3'h0;
    end else begin
      in_meta_r <= {portb_bit0_in, porta_bit5_in, porta_bit4_in};
      in_sync_r <= in_meta_r;
    end
  end

  // Write channel: address and data accepted in either order
  // The write waits for both halves, so the master may send them in any order
  assign do_write = aw_have_r && w_have_r && (wr_state_r == pwm_pkg::WR_IDLE);
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_r          <= 12'h000;
      w_r           <= 32'h0000_0000;
      ws_r          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && (wr_state_r == pwm_pkg::WR_IDLE);
      s_axi_wready  <= !w_have_r && !s_axi_wready && (wr_state_r == pwm_pkg::WR_IDLE);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_r      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_r      <= s_axi_wdata;
        ws_r     <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end
    end
  end

  // Write response: OKAY for mapped, SLVERR for unmapped
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_state_r   <= pwm_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      case (wr_state_r)
        pwm_pkg::WR_IDLE: begin
          if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_addr(aw_r) ? 2'h0 : 2'h2;
            wr_state_r   <= pwm_pkg::WR_RESP;
          end
        end
        pwm_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_r   <= pwm_pkg::WR_IDLE;
          end
        end
        default: wr_state_r <= pwm_pkg::WR_IDLE;
      endcase
    end
  end

  // Register file writes; only byte lane 0 carries data
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        duty_low_r[i]    <= `RESET_BYTE;
        duty_high_r[i]   <= `RESET_BYTE;
        base_period_r[i] <= `RESET_BYTE;
      end
      clk_sel_r           <= 3'h0;
      porta_direction_r   <= `RESET_DIR;
      portb_direction_r   <= `RESET_DIR;
      porta_output_data_r <= `RESET_BYTE;
      portb_output_data_r <= `RESET_BYTE;
    end else if (do_write && ws_r[0]) begin
      case (aw_r)
        `OFS_CH0_DUTY_LOW:  duty_low_r[0]       <= w_r[7:0];
        `OFS_CH0_DUTY_HIGH: duty_high_r[0]      <= w_r[7:0];
        `OFS_CH1_DUTY_LOW:  duty_low_r[1]       <= w_r[7:0];
        `OFS_CH1_DUTY_HIGH: duty_high_r[1]      <= w_r[7:0];
        `OFS_CH2_DUTY_LOW:  duty_low_r[2]       <= w_r[7:0];
        `OFS_CH2_DUTY_HIGH: duty_high_r[2]      <= w_r[7:0];
        `OFS_BASE_PERIOD_0: base_period_r[0]    <= w_r[7:0];
        `OFS_BASE_PERIOD_1: base_period_r[1]    <= w_r[7:0];
        `OFS_BASE_PERIOD_2: base_period_r[2]    <= w_r[7:0];
        `OFS_CLK_SELECT:    clk_sel_r           <= w_r[2:0];
        `OFS_PORTA_DIR:     porta_direction_r   <= w_r[7:0];
        `OFS_PORTB_DIR:     portb_direction_r   <= w_r[7:0];
        `OFS_PORTA_DATA:    porta_output_data_r <= w_r[7:0];
        `OFS_PORTB_DATA:    portb_output_data_r <= w_r[7:0];
        // Status word is read-only, so writes to it land here and are dropped
        default: ;
      endcase
    end
  end

  // Read mux; pin status shows synchronised pins and live waves
  always_comb begin
    case (s_axi_araddr)
      `OFS_CH0_DUTY_LOW:  rd_val = {24'h0000_00, duty_low_r[0]};
      `OFS_CH0_DUTY_HIGH: rd_val = {24'h0000_00, duty_high_r[0]};
      `OFS_CH1_DUTY_LOW:  rd_val = {24'h0000_00, duty_low_r[1]};
      `OFS_CH1_DUTY_HIGH: rd_val = {24'h0000_00, duty_high_r[1]};
      `OFS_CH2_DUTY_LOW:  rd_val = {24'h0000_00, duty_low_r[2]};
      `OFS_CH2_DUTY_HIGH: rd_val = {24'h0000_00, duty_high_r[2]};
      `OFS_BASE_PERIOD_0: rd_val = {24'h0000_00, base_period_r[0]};
      `OFS_BASE_PERIOD_1: rd_val = {24'h0000_00, base_period_r[1]};
      `OFS_BASE_PERIOD_2: rd_val = {24'h0000_00, base_period_r[2]};
      `OFS_CLK_SELECT:    rd_val = {29'h0000_0000, clk_sel_r};
      `OFS_PORTA_DIR:     rd_val = {24'h0000_00, porta_direction_r};
      `OFS_PORTB_DIR:     rd_val = {24'h0000_00, portb_direction_r};
      `OFS_PORTA_DATA:    rd_val = {24'h0000_00, porta_output_data_r};
      `OFS_PORTB_DATA:    rd_val = {24'h0000_00, portb_output_data_r};
      `OFS_PIN_STATUS:    rd_val = {26'h0000_000, wave, in_sync_r};
      default:            rd_val = 32'h0000_0000;
    endcase
  end

  // Read channel: one read at a time, answer one cycle after address
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_state_r    <= pwm_pkg::RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      case (rd_state_r)
        pwm_pkg::RD_IDLE: begin
          // Ready pulses every other cycle while idle; a held request is taken anyway
          s_axi_arready <= !s_axi_arready;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= known_addr(s_axi_araddr) ? 2'h0 : 2'h2;
            rd_state_r    <= pwm_pkg::RD_RESP;
          end
        end
        pwm_pkg::RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_r   <= pwm_pkg::RD_IDLE;
          end
        end
        default: rd_state_r <= pwm_pkg::RD_IDLE;
      endcase
    end
  end
endmodule

// *** testbench/pwm_top_asserts.sv ***
// Register bus response checker bound to the PWM top
`timescale 1ns/10ps
module pwm_top_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Responses stand unchanged until the master takes them
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response moved early");
  a_rresp_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response moved early");
  // Read data follows the address handshake by one cycle
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // A pending write response blocks new write traffic
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_bresp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  // Only OKAY or SLVERR, and an error read returns zero
  a_rresp_legal: assert property (s_axi_rvalid |->
    s_axi_rresp == 2'h0 || (s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000))
    else $error("bad read response");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
endmodule

bind pwm_top pwm_top_asserts chk (
  .clk(clk), .reset(reset), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** testbench/pin_load.sv ***
// Load on one shared pin: pull-up, optional sink, and waveform meters
`timescale 1ns/10ps
module pin_load (
  input  wire logic   clk,
  input  wire logic   drive,
  input  wire logic   drive_en,
  input  wire logic   pull_low,
  input  wire logic   clr,
  input  wire logic   measure,
  output logic        level,
  output logic [15:0] high_cnt,
  output logic [15:0] rise_cnt,
  output logic [15:0] max_run
);
  logic [15:0] run_r;
  logic        prev_r = 1'b0;
  // Undriven pin rests high through its pull-up unless the load sinks it
  assign level = drive_en ? drive : !pull_low;
  // High time, rising edges and longest high run inside the window
  always @(posedge clk) begin
    prev_r <= level;
    if (clr) begin
      high_cnt <= 16'h0000;
      rise_cnt <= 16'h0000;
      max_run <= 16'h0000;
      run_r <= 16'h0000;
    end else if (measure) begin
      high_cnt <= high_cnt + {15'h0000, level};
      if (level && !prev_r) rise_cnt <= rise_cnt + 16'h0001;
      run_r <= level ? run_r + 16'h0001 : 16'h0000;
      if (!level && prev_r && run_r > max_run) max_run <= run_r;
    end
  end
endmodule

// *** testbench/tb_three_channel_pwm_8p4.sv ***
// Self-checking bench for the three-channel 8+4 PWM block
`timescale 1ns/10ps
`include "pwm_params.svh"
module tb_three_channel_pwm_8p4;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  pout, poe, lvl;
  logic [2:0]  pull_low = 3'h0;
  logic        clr = 1'b0;
  logic        measure = 1'b0;
  logic [15:0] hi [3];
  logic [15:0] rise [3];
  logic [15:0] run [3];
  int          num_errors = 0;
  int          num_checks = 0;

  // 50 MHz system clock
  always #10 clk = ~clk;

  pwm_top dut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .porta_bit4_in(lvl[0]), .porta_bit5_in(lvl[1]), .portb_bit0_in(lvl[2]),
    .porta_bit4_out(pout[0]), .porta_bit4_oe(poe[0]), .porta_bit5_out(pout[1]),
    .porta_bit5_oe(poe[1]), .portb_bit0_out(pout[2]), .portb_bit0_oe(poe[2]));

  // One load per shared pin
  for (genvar g = 0; g < 3; g++) begin : g_load
    pin_load u_load (.clk(clk), .drive(pout[g]), .drive_en(poe[g]), .pull_low(pull_low[g]),
      .clr(clr), .measure(measure), .level(lvl[g]), .high_cnt(hi[g]), .rise_cnt(rise[g]),
      .max_run(run[g]));
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts a bounded wait; a hang ends the run
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 100) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int  n;
    bit  aw_ok;
    bit  w_ok;
    n = 0;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      tick(n);
      if (!aw_ok && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do tick(n); while (!bvalid);
    // Ready comes late so the response has to stand through a wait
    bready <= 1'b1;
    tick(n);
    check("write response held", {31'h0, bvalid}, 32'h0000_0001);
    check("write response", {30'h0, bresp}, 32'h0000_0000);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do tick(n); while (!arready);
    arvalid <= 1'b0;
    do tick(n); while (!rvalid);
    // Data taken at the edge where the late ready is sampled
    rready <= 1'b1;
    tick(n);
    check("read data held", {31'h0, rvalid}, 32'h0000_0001);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic window(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    measure <= 1'b1;
    repeat (n) @(posedge clk);
    measure <= 1'b0;
    @(posedge clk);
  endtask

  // Reset values, read-write period register, unmapped address
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`OFS_BASE_PERIOD_0, d, r);
    check("period0 reset", d, 32'h0000_0000);
    rd(`OFS_PORTA_DIR, d, r);
    check("porta dir reset", d, 32'h0000_00ff);
    wr(`OFS_BASE_PERIOD_1, 8'ha5);
    rd(`OFS_BASE_PERIOD_1, d, r);
    check("period1 readback", d, 32'h0000_00a5);
    wr(`OFS_BASE_PERIOD_1, 8'h00);
    rd(12'h03c, d, r);
    check("unmapped resp", {30'h0, r}, 32'h0000_0002);
    $display("test regs done");
  endtask

  // Three channels, three clockings, one 16384-clock window holds whole cycles of each
  task automatic t_waves();
    wr(`OFS_CH0_DUTY_LOW, 8'h0b);
    wr(`OFS_CH0_DUTY_HIGH, 8'h34);
    wr(`OFS_CH1_DUTY_LOW, 8'h1f);
    wr(`OFS_CH1_DUTY_HIGH, 8'h7f);
    wr(`OFS_CH2_DUTY_LOW, 8'h01);
    wr(`OFS_CH2_DUTY_HIGH, 8'h01);
    wr(`OFS_BASE_PERIOD_2, 8'h01);
    wr(`OFS_CLK_SELECT, 8'h02);
    wr(`OFS_PORTA_DATA, 8'h30);
    wr(`OFS_PORTB_DATA, 8'h01);
    wr(`OFS_PORTA_DIR, 8'h00);
    wr(`OFS_PORTB_DIR, 8'h00);
    repeat (32768) @(posedge clk);
    window(16384);
    check("pins driven", {29'h0, poe}, 32'h0000_0007);
    check("ch0 high", {16'h0, hi[0]}, 32'h0000_0d14);
    check("ch0 rises", {16'h0, rise[0]}, 32'h0000_0040);
    check("ch0 run", {16'h0, run[0]}, 32'h0000_0035);
    check("ch1 high", {16'h0, hi[1]}, 32'h0000_1ffc);
    check("ch1 rises", {16'h0, rise[1]}, 32'h0000_0010);
    check("ch1 run", {16'h0, run[1]}, 32'h0000_0200);
    check("ch2 high", {16'h0, hi[2]}, 32'h0000_0040);
    check("ch2 rises", {16'h0, rise[2]}, 32'h0000_0020);
    check("ch2 run", {16'h0, run[2]}, 32'h0000_0002);
    $display("test waves done");
  endtask

  // Port data gating, input direction, and enable off
  task automatic t_gating();
    logic [31:0] d;
    logic [1:0]  r;
    wr(`OFS_PORTA_DATA, 8'h20);
    repeat (4) @(posedge clk);
    window(300);
    check("ch0 forced low", {16'h0, hi[0]}, 32'h0000_0000);
    wr(`OFS_PORTA_DIR, 8'h20);
    repeat (4) @(posedge clk);
    check("ch1 released", {31'h0, poe[1]}, 32'h0000_0000);
    rd(`OFS_PIN_STATUS, d, r);
    check("ch1 pin pulled up", {31'h0, d[1]}, 32'h0000_0001);
    pull_low[1] <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`OFS_PIN_STATUS, d, r);
    check("ch1 pin sunk", {31'h0, d[1]}, 32'h0000_0000);
    wr(`OFS_CH2_DUTY_LOW, 8'h00);
    repeat (16384) @(posedge clk);
    window(300);
    check("ch2 plain data", {16'h0, hi[2]}, 32'h0000_012c);
    $display("test gating done");
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_waves();
    t_gating();
    tally_and_finish();
  end
endmodule
